// File: logic/pdpio_params.svh
// Constants for the port direction and pull-up block
`ifndef PDPIO_PARAMS_SVH
`define PDPIO_PARAMS_SVH

// Port data addresses
`define PDPIO_ADDR_P0 16'hFF00
`define PDPIO_ADDR_P1 16'hFF01
`define PDPIO_ADDR_P2 16'hFF02
`define PDPIO_ADDR_P5 16'hFF05
`define PDPIO_ADDR_P6 16'hFF06
// Direction register addresses
`define PDPIO_ADDR_PM0 16'hFF20
`define PDPIO_ADDR_PM1 16'hFF21
`define PDPIO_ADDR_PM2 16'hFF22
`define PDPIO_ADDR_PM5 16'hFF25
// Pull-up select addresses
`define PDPIO_ADDR_PORT2_PULLUP_REG 16'hFF32
`define PDPIO_ADDR_PU0 16'hFFF7

// Reset values
`define PDPIO_DIR_RST 8'hFF
`define PDPIO_PU_RST 8'h00
`define PDPIO_LATCH_RST 8'h00

// Implemented bit masks
`define PDPIO_MASK_P0 8'h0F
`define PDPIO_MASK_P1 8'h03
`define PDPIO_MASK_P2 8'h3F
`define PDPIO_MASK_P5 8'h0F
`define PDPIO_MASK_PU0 8'h03
`define PDPIO_MASK_PORT2_PULLUP_REG 8'h3F

// Field positions
`define PDPIO_P2_TMR_PIN 4
`define PDPIO_P2_IRQ_LO 3
`define PDPIO_NUM_PORTS 4
`define PDPIO_NUM_PINS 16

`endif

// File: logic/pdpio_pkg.sv
// Types for the port direction and pull-up block
package pdpio_pkg;

	// CPU access to the block
	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic rd;
		logic bitop;
		logic [2:0] bitsel;
		logic bitval;
		logic [7:0] wdata;
	} pdpio_bus_t;

	// Pad controls: p0 [3:0], p1 [5:4], p2 [11:6], p5 [15:12]
	typedef struct packed {
		logic [15:0] out;
		logic [15:0] oe;
		logic [15:0] pu;
	} pdpio_pad_t;

endpackage

// File: logic/pdpio_top.sv
// Port latches, direction control and pull-up selection
`timescale 1ns/1ps
`include "pdpio_params.svh"

// Functional notes
// R1: Direction bit 0 enables output buffer; 1 makes pin input.
// R2: Reset loads every direction register with all ones.
// R3: Direction registers take single-bit and byte writes independently.
// R4: Software sets direction and latch correctly for alternate functions.
// R5: Port 2 interrupt pin in output mode changing level sets request.
// R6: Software masks port 2 interrupts before using output mode.
// R7: Ports 0 and 1 pull-ups connect only on input-mode bits.
// R8: Input-gated pull-up withheld from alternate-function output pins.
// R9: Input pull-up register: bits 0,1 used, rest zero, reset clear.
// R10: Port 2 pull-up bit connects pull-up in either direction.
// R11: Port 2 pull-up register: bits 0-5, upper zero, reset clear.
// R12: Output-mode write updates latch, latch drives the pin.
// R13: Input-mode write updates latch only; pin left undriven.
// R14: Output-mode read returns latch, latch unchanged.
// R15: Input-mode read returns pin level, latch unchanged.
// R16: Bit operation on a port is a whole byte read-modify-write.
// R17: Output-mode arithmetic uses latch, writes result, drives pins.
// R18: Input-mode arithmetic leaves latch undefined, pin unchanged.
// R19: Software reads port 5 three times on flash parts.
// R20: Port 2 has six bidirectional pins, inputs after reset.
// R21: Port 6 is a four-pin input-only port.
module pdpio_top (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire pdpio_pkg::pdpio_bus_t bus_i,
	output logic [7:0] rdata_o,
	input wire logic [15:0] pad_in_i,
	input wire logic [3:0] p6_in_i,
	input wire logic [5:0] alt_out_active_i,
	input wire logic timer_a_output_i,
	input wire logic timer_b_output_i,
	output pdpio_pkg::pdpio_pad_t pad_o,
	output logic [2:0] ext_irq_set_o
);

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------

	// Port index from a latch address, bit 2 flags a hit
	function automatic logic [2:0] latch_hit(input logic [15:0] a);
		case (a)
			`PDPIO_ADDR_P0: latch_hit = 3'h4;
			`PDPIO_ADDR_P1: latch_hit = 3'h5;
			`PDPIO_ADDR_P2: latch_hit = 3'h6;
			`PDPIO_ADDR_P5: latch_hit = 3'h7;
			default: latch_hit = 3'h0;
		endcase
	endfunction

	// Port index from a direction address, bit 2 flags a hit
	function automatic logic [2:0] dir_hit(input logic [15:0] a);
		case (a)
			`PDPIO_ADDR_PM0: dir_hit = 3'h4;
			`PDPIO_ADDR_PM1: dir_hit = 3'h5;
			`PDPIO_ADDR_PM2: dir_hit = 3'h6;
			`PDPIO_ADDR_PM5: dir_hit = 3'h7;
			default: dir_hit = 3'h0;
		endcase
	endfunction

	// Replaces one bit of a byte
	function automatic logic [7:0] set_bit(input logic [7:0] b, input logic [2:0] s,
		input logic v);
		logic [7:0] r;
		r = b;
		r[s] = v;
		set_bit = r;
	endfunction

	// Implemented bits of each port
	function automatic logic [7:0] port_mask(input logic [1:0] i);
		case (i)
			2'h0: port_mask = `PDPIO_MASK_P0;
			2'h1: port_mask = `PDPIO_MASK_P1;
			2'h2: port_mask = `PDPIO_MASK_P2;
			default: port_mask = `PDPIO_MASK_P5;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------

	logic [19:0] pin_meta_reg;
	logic [19:0] pin_sync_reg;

	// Two flops on every pin input before use
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_meta_reg <= 20'h00000;
			pin_sync_reg <= 20'h00000;
		end else begin
			pin_meta_reg <= {p6_in_i, pad_in_i};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------

	logic [7:0] dir_reg [`PDPIO_NUM_PORTS];
	logic [7:0] latch_reg [`PDPIO_NUM_PORTS];
	logic [7:0] input_pullup_reg;
	logic [7:0] port2_pullup_reg;
	logic [7:0] rdata_reg;
	logic [2:0] irq_reg;
	logic [2:0] p2_drv_prev_reg;

	logic [7:0] pin_lvl [`PDPIO_NUM_PORTS];
	logic [7:0] port_rd [`PDPIO_NUM_PORTS];
	logic [2:0] lhit;
	logic [2:0] dhit;
	logic hit_pu0;
	logic hit_port2_pullup_reg;
	logic [7:0] port_base;
	logic [7:0] port_wval;
	logic [7:0] dir_wval;
	logic [7:0] pu0_wval;
	logic [7:0] port2_pullup_reg_wval;
	logic [7:0] rd_val;
	logic [7:0] p2_drv;
	logic [2:0] irq_next;

	// Address decode
	assign lhit = latch_hit(bus_i.addr);
	assign dhit = dir_hit(bus_i.addr);
	assign hit_pu0 = (bus_i.addr == `PDPIO_ADDR_PU0);
	assign hit_port2_pullup_reg = (bus_i.addr == `PDPIO_ADDR_PORT2_PULLUP_REG);

	// Synchronised pin levels per port
	assign pin_lvl[0] = {4'h0, pin_sync_reg[3:0]};
	assign pin_lvl[1] = {6'h00, pin_sync_reg[5:4]};
	assign pin_lvl[2] = {2'h0, pin_sync_reg[11:6]};
	assign pin_lvl[3] = {4'h0, pin_sync_reg[15:12]};

	// Per-port latch and direction logic
	genvar gi;
	generate
		for (gi = 0; gi < `PDPIO_NUM_PORTS; gi++) begin : g_port
			// R14 R15: read mixes latch and pin by direction
			assign port_rd[gi] = ((dir_reg[gi] & pin_lvl[gi]) |
				(~dir_reg[gi] & latch_reg[gi])) & port_mask(2'(gi));

			// R2 R3: direction reset and byte or bit writes
			always_ff @(posedge mclk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					dir_reg[gi] <= `PDPIO_DIR_RST;
				end else if (bus_i.wr && dhit == {1'b1, 2'(gi)}) begin
					dir_reg[gi] <= dir_wval | ~port_mask(2'(gi));
				end
			end

			// R12 R13 R16 R17 R18: latch written in either mode
			always_ff @(posedge mclk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					latch_reg[gi] <= `PDPIO_LATCH_RST;
				end else if (bus_i.wr && lhit == {1'b1, 2'(gi)}) begin
					latch_reg[gi] <= port_wval & port_mask(2'(gi));
				end
			end
		end
	endgenerate

	// R16: bit operation on a port starts from the whole-byte read
	assign port_base = port_rd[lhit[1:0]];
	assign port_wval = bus_i.bitop ? set_bit(port_base, bus_i.bitsel, bus_i.bitval)
		: bus_i.wdata;

	// R3: bit writes touch only the addressed direction bit
	assign dir_wval = bus_i.bitop
		? set_bit(dir_reg[dhit[1:0]], bus_i.bitsel, bus_i.bitval) : bus_i.wdata;

	// Pull-up write values
	assign pu0_wval = bus_i.bitop
		? set_bit(input_pullup_reg, bus_i.bitsel, bus_i.bitval) : bus_i.wdata;
	assign port2_pullup_reg_wval = bus_i.bitop
		? set_bit(port2_pullup_reg, bus_i.bitsel, bus_i.bitval) : bus_i.wdata;

	// R9 R11: pull-up selects, unused bits held at zero
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			input_pullup_reg <= `PDPIO_PU_RST;
			port2_pullup_reg <= `PDPIO_PU_RST;
		end else begin
			if (bus_i.wr && hit_pu0)
				input_pullup_reg <= pu0_wval & `PDPIO_MASK_PU0;
			if (bus_i.wr && hit_port2_pullup_reg)
				port2_pullup_reg <= port2_pullup_reg_wval & `PDPIO_MASK_PORT2_PULLUP_REG;
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------

	// R21: port 6 reads pins only; unmapped reads zero
	assign rd_val = lhit[2] ? port_rd[lhit[1:0]]
		: dhit[2] ? dir_reg[dhit[1:0]]
		: hit_pu0 ? input_pullup_reg
		: hit_port2_pullup_reg ? port2_pullup_reg
		: (bus_i.addr == `PDPIO_ADDR_P6) ? {4'h0, pin_sync_reg[19:16]}
		: 8'h00;

	// Read data captured one cycle after the strobe
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_reg <= 8'h00;
		end else if (bus_i.rd) begin
			rdata_reg <= rd_val;
		end
	end

	assign rdata_o = rdata_reg;

	// ------------------------------------------------------------
	// Pad drive
	// ------------------------------------------------------------

	// Port 2 drive level, timer outputs merged on pin 4
	always_comb begin
		p2_drv = latch_reg[2];
		p2_drv[`PDPIO_P2_TMR_PIN] = latch_reg[2][`PDPIO_P2_TMR_PIN] |
			timer_a_output_i | timer_b_output_i;
	end

	// R1 R12: latch drives the pin when its direction bit is 0
	assign pad_o.out = {4'h0, p2_drv[5:0], latch_reg[1][1:0], latch_reg[0][3:0]};
	// R1 R13 R20: buffer off in input mode; port 5 only sinks low
	assign pad_o.oe = {~dir_reg[3][3:0] & ~latch_reg[3][3:0], ~dir_reg[2][5:0],
		~dir_reg[1][1:0], ~dir_reg[0][3:0]};

	// R7 R8 R10: pull-ups gated by direction for ports 0 and 1 only
	assign pad_o.pu = {4'h0, port2_pullup_reg[5:0],
		{2{input_pullup_reg[1]}} & dir_reg[1][1:0] & ~alt_out_active_i[5:4],
		{4{input_pullup_reg[0]}} & dir_reg[0][3:0] & ~alt_out_active_i[3:0]};

	// ------------------------------------------------------------
	// Interrupt request on output level change
	// ------------------------------------------------------------

	// R5: level change on an output-mode interrupt pin
	assign irq_next = ~dir_reg[2][5:3] & (p2_drv[5:3] ^ p2_drv_prev_reg);

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			p2_drv_prev_reg <= 3'h0;
			irq_reg <= 3'h0;
		end else begin
			p2_drv_prev_reg <= p2_drv[5:3];
			irq_reg <= irq_next;
		end
	end

	assign ext_irq_set_o = irq_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_p0_byte_write;
		bus_i.wr && !bus_i.bitop && bus_i.addr == `PDPIO_ADDR_P0;
	endsequence

	property p_dir_oe;
		pad_o.oe[3:0] == ~dir_reg[0][3:0] && pad_o.oe[11:6] == ~dir_reg[2][5:0];
	endproperty
	a_dir_oe: assert property (p_dir_oe) else $error("oe does not follow direction"); // R1

	property p_dir_bitwrite;
		(bus_i.wr && bus_i.bitop && bus_i.addr == `PDPIO_ADDR_PM2 && bus_i.bitsel == 3'h4)
		|=> dir_reg[2][3] == $past(dir_reg[2][3]) && dir_reg[2][4] == $past(bus_i.bitval);
	endproperty
	a_dir_bitwrite: assert property (p_dir_bitwrite) else $error("direction bit write"); // R3

	property p_irq_set;
		(dir_reg[2][4] == 1'b0 && $changed(p2_drv[4])) |=> ext_irq_set_o[1];
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("missing irq on level change"); // R5

	property p_irq_quiet;
		(dir_reg[2][5:3] == 3'h7) |=> ext_irq_set_o == 3'h0;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("irq in input mode"); // R5

	property p_pu_gate;
		(dir_reg[0][2] == 1'b0) |-> pad_o.pu[2] == 1'b0;
	endproperty
	a_pu_gate: assert property (p_pu_gate) else $error("pull-up on output pin"); // R7

	property p_port2_pullup_reg;
		pad_o.pu[11:6] == port2_pullup_reg[5:0];
	endproperty
	a_port2_pullup_reg: assert property (p_port2_pullup_reg) else $error("port 2 pull-up mismatch"); // R10

	property p_pu_zero;
		input_pullup_reg[7:2] == 6'h00 && port2_pullup_reg[7:6] == 2'h0;
	endproperty
	a_pu_zero: assert property (p_pu_zero) else $error("fixed pull-up bits set"); // R11

	property p_latch_write;
		s_p0_byte_write |=> latch_reg[0][3:0] == $past(bus_i.wdata[3:0]) ##1
			latch_reg[0] == $past(latch_reg[0]) || $past(bus_i.wr);
	endproperty
	a_latch_write: assert property (p_latch_write) else $error("latch write lost"); // R12

	property p_read_out;
		(bus_i.rd && bus_i.addr == `PDPIO_ADDR_P1 && dir_reg[1][1:0] == 2'h0)
		|=> rdata_o == {6'h00, $past(latch_reg[1][1:0])};
	endproperty
	a_read_out: assert property (p_read_out) else $error("output read not latch"); // R14

endmodule // pdpio_top

// File: dv/pdpio_board.sv
// Board model that resolves the port pin levels
`timescale 1ns/1ps
module pdpio_board (
	input wire pdpio_pkg::pdpio_pad_t pad_i,
	input wire logic [15:0] float_i,
	output logic [15:0] pin_o
);
	// Driven pins follow the drive, pulled pins read high, others float
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			pin_o[i] = pad_i.oe[i] ? pad_i.out[i] : (pad_i.pu[i] ? 1'b1 : float_i[i]);
		end
	end
endmodule // pdpio_board

// File: dv/tb_top.sv
// Self-checking bench for the port block
`timescale 1ns/1ps
`define TB_CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin error_cnt++; \
	$display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
	localparam logic [15:0] A_L0 = 16'hFF00, A_L1 = 16'hFF01, A_L2 = 16'hFF02, A_L5 = 16'hFF05;
	localparam logic [15:0] A_L6 = 16'hFF06, A_D0 = 16'hFF20, A_D1 = 16'hFF21, A_D2 = 16'hFF22;
	localparam logic [15:0] A_D5 = 16'hFF25, A_IPU = 16'hFFF7, A_P2PU = 16'hFF32;
	logic mclk_i = 1'b0;
	logic nrst_i = 1'b0;
	pdpio_pkg::pdpio_bus_t bus_i = '0;
	logic [7:0] rdata_o;
	logic [15:0] pad_in_i;
	logic [3:0] p6_in_i = 4'h0;
	logic [5:0] alt_out_active_i = 6'h00;
	logic timer_a_output_i = 1'b0;
	logic timer_b_output_i = 1'b0;
	pdpio_pkg::pdpio_pad_t pad_o;
	logic [2:0] ext_irq_set_o;
	logic [15:0] fl = 16'h0000;
	logic [7:0] exp_q[$];
	logic [7:0] rv;
	logic [7:0] p2v;
	logic rd_pend = 1'b0;
	int error_cnt = 0;
	int comparisons = 0;
	int seed = 32'hf3ee;
	logic [3:0] irq_cnt;

	pdpio_top dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .bus_i(bus_i), .rdata_o(rdata_o),
		.pad_in_i(pad_in_i), .p6_in_i(p6_in_i), .alt_out_active_i(alt_out_active_i),
		.timer_a_output_i(timer_a_output_i), .timer_b_output_i(timer_b_output_i),
		.pad_o(pad_o), .ext_irq_set_o(ext_irq_set_o));
	pdpio_board board (.pad_i(pad_o), .float_i(fl), .pin_o(pad_in_i));

	// Clock
	initial begin
		forever #2.5 mclk_i = ~mclk_i;
	end

	// One bus access, request held for one sampling edge
	task automatic acc(input logic [15:0] a, input logic w, input logic r, input logic b,
		input logic [2:0] s, input logic [7:0] d);
		@(posedge mclk_i);
		bus_i <= '{addr: a, wr: w, rd: r, bitop: b, bitsel: s, bitval: d[0], wdata: d};
		@(posedge mclk_i);
		bus_i.wr <= 1'b0;
		bus_i.rd <= 1'b0;
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		acc(a, 1'b1, 1'b0, 1'b0, 3'd0, d);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		acc(a, 1'b0, 1'b1, 1'b0, 3'd0, 8'h00);
	endtask
	task automatic tally_and_finish;
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Read monitor: oldest note against the settled read data
	always @(negedge mclk_i) begin
		if (rd_pend) begin
			rv = exp_q.pop_front();
			`TB_CHK("rdata", rv, rdata_o)
		end
		rd_pend = bus_i.rd;
	end

	// Watchdog
	initial begin
		#20000;
		error_cnt++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		repeat (3) @(posedge mclk_i);
		`TB_CHK("oe", 16'h0000, pad_o.oe)
		`TB_CHK("pu", 16'h0000, pad_o.pu)
		nrst_i <= 1'b1;
		fl <= 16'($random(seed));
		p6_in_i <= 4'($random(seed));
		rd(A_D2, 8'hFF);
		rd(A_IPU, 8'h00);
		rd(A_P2PU, 8'h00);
		rd(16'hFF10, 8'h00);
		// Input-mode latch write on interrupt pins leaves pins and requests alone
		wr(A_L2, 8'h28);
		`TB_CHK("p2 oe", 6'h00, pad_o.oe[11:6])
		repeat (3) begin
			@(negedge mclk_i);
			`TB_CHK("irq input mode", 3'h0, ext_irq_set_o)
		end
		// Output mode write, read and arithmetic
		wr(A_D0, 8'h00);
		wr(A_L0, 8'h05);
		`TB_CHK("p0 out", 4'h5, pad_o.out[3:0])
		`TB_CHK("p0 oe", 4'hF, pad_o.oe[3:0])
		rd(A_L0, 8'h05);
		wr(A_L0, 8'h05 + 8'h03);
		`TB_CHK("p0 sum", 4'h8, pad_o.out[3:0])
		// Input mode write keeps pins, read sees pins
		wr(A_L1, 8'h02);
		`TB_CHK("p1 oe", 2'b00, pad_o.oe[5:4])
		rd(A_L1, {6'h00, fl[5:4]});
		wr(A_D1, 8'h00);
		rd(A_L1, 8'h02);
		`TB_CHK("p1 out", 2'b10, pad_o.out[5:4])
		// Single-bit direction write stays local
		acc(A_D2, 1'b1, 1'b0, 1'b1, 3'd4, 8'h00);
		rd(A_D2, 8'hEF);
		rd(A_D0, 8'hF0);
		// Interrupt mask left to software; bit set on latch is a byte access
		acc(A_L2, 1'b1, 1'b0, 1'b1, 3'd4, 8'h01);
		irq_cnt = 4'h0;
		repeat (6) begin
			@(negedge mclk_i);
			irq_cnt += {3'h0, ext_irq_set_o[1]};
			`TB_CHK("irq others", 2'b00, {ext_irq_set_o[2], ext_irq_set_o[0]})
		end
		`TB_CHK("irq count", 4'h1, irq_cnt)
		p2v = {2'b00, fl[11], 1'b1, fl[9:6]};
		wr(A_D2, 8'h00);
		rd(A_L2, p2v);
		`TB_CHK("p2 out", p2v[5:0], pad_o.out[11:6])
		// Timer outputs on port 2 pin 4 with latch cleared
		wr(A_L2, 8'h00);
		@(posedge mclk_i);
		timer_a_output_i <= 1'b1;
		@(negedge mclk_i);
		`TB_CHK("timer a", 1'b1, pad_o.out[10])
		@(posedge mclk_i);
		timer_a_output_i <= 1'b0;
		timer_b_output_i <= 1'b1;
		@(negedge mclk_i);
		`TB_CHK("timer b", 1'b1, pad_o.out[10])
		@(posedge mclk_i);
		timer_b_output_i <= 1'b0;
		@(negedge mclk_i);
		`TB_CHK("timer off", 1'b0, pad_o.out[10])
		// Pull-up selection
		wr(A_IPU, 8'hFF);
		rd(A_IPU, 8'h03);
		wr(A_P2PU, 8'hFF);
		rd(A_P2PU, 8'h3F);
		@(posedge mclk_i);
		alt_out_active_i <= 6'($random(seed));
		wr(A_D0, 8'h03);
		`TB_CHK("pu", {4'h0, 6'h3F, 2'b00, 4'h3 & ~alt_out_active_i[3:0]}, pad_o.pu)
		acc(A_IPU, 1'b1, 1'b0, 1'b1, 3'd0, 8'h00);
		rd(A_IPU, 8'h02);
		acc(A_P2PU, 1'b1, 1'b0, 1'b1, 3'd5, 8'h00);
		rd(A_P2PU, 8'h1F);
		// Open-drain port and three reads in input mode
		wr(A_L5, 8'h05);
		wr(A_D5, 8'h00);
		`TB_CHK("p5 oe", 4'hA, pad_o.oe[15:12])
		wr(A_D5, 8'hFF);
		// Released pins need two sync stages before they read back
		repeat (2) @(posedge mclk_i);
		repeat (3) rd(A_L5, {4'h0, fl[15:12]});
		// Input-only port ignores writes
		rd(A_L6, {4'h0, p6_in_i});
		wr(A_L6, 8'hFF);
		rd(A_L6, {4'h0, p6_in_i});
		// Mid-run reset returns every pin to input mode, pull-ups off
		@(posedge mclk_i);
		nrst_i <= 1'b0;
		@(negedge mclk_i);
		`TB_CHK("oe in reset", 16'h0000, pad_o.oe)
		`TB_CHK("pu in reset", 16'h0000, pad_o.pu)
		@(posedge mclk_i);
		nrst_i <= 1'b1;
		rd(A_D0, 8'hFF);
		rd(A_P2PU, 8'h00);
		repeat (3) @(posedge mclk_i);
		tally_and_finish();
	end
endmodule // tb_top
